//--- hw/tapg_defs.svh
// Clock frequency and reset values for the thermal alarm and power-good sideband.
`ifndef TAPG_DEFS_SVH
`define TAPG_DEFS_SVH
`define TAPG_CLK_HZ 10000000
`define TAPG_BIDIR_EN_RST 1'b0
`define TAPG_GATED_RST 1'b1
`endif

//--- hw/tapg_pkg.sv
// Types shared by the thermal alarm and power-good sideband.
package tapg_pkg;
   typedef enum logic [4:0] {
      TAPG_PS_HIGH_FREQ = 5'h01,
      TAPG_PS_MID_FREQ = 5'h02,
      TAPG_PS_LOW_FREQ = 5'h04,
      TAPG_PS_DEEP_SLEEP = 5'h08,
      TAPG_PS_DEEPER_SLEEP = 5'h10
   } tapg_pstate_type;

   typedef struct packed {
      logic throttleEnable;
      logic bidirEnableReq;
   } tapg_ctrl_type;

   typedef struct packed {
      logic alarmOut;
      logic alarmOe_n;
   } tapg_pin_type;

   typedef enum logic [1:0] {
      TAPG_GATED = 2'h1,
      TAPG_RUN = 2'h2
   } tapg_guard_type;
endpackage

//--- hw/tapg_sideband.sv
// Thermal alarm pin, power-state indicator and power-good qualification logic.
`timescale 1ns/1ps
`include "tapg_defs.svh"
//
// Function
// R1 - Drive thermal_alarm_n low when the sensor reports maximum safe temperature.
// R2 - Throttle unit is active whenever the alarm goes out, if enabled.
// R3 - External alarm assertion in bidirectional mode activates throttling, if enabled.
// R4 - Throttling from the external alarm lasts until the platform releases it; the code drops it for two cycles after its own drive ends.
// R5 - After reset the alarm pin is output only until firmware enables bidirection.
// R6 - Assert power_state_indicator_n from high to low freq and in deep sleeps.
// R7 - Platform holds supply_ok low cleanly, then rises monotonically.
// R8 - Platform may drop supply_ok anytime; stable supplies before next rise.
// R9 - Platform always supplies supply_ok, high during boundary scan.
// R10 - supply_ok low gates the logic; resume only after a new rising edge.
module tapg_sideband
   import tapg_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic sensorAtMaxTemp,
   input wire tapg_ctrl_type ctrl,
   input wire tapg_pstate_type powerState,
   input wire logic supplyOk,
   input wire logic thermalAlarmIn_n,
   output tapg_pin_type thermalAlarm,
   output logic thermalThrottleUnit,
   output logic powerStateIndicator_n,
   output logic bidirEnabled,
   output logic logicGated
);

   // ******************************************************************
   // Input synchronisers
   // ******************************************************************
   logic supplyMeta, supplySync, supplyPrev;
   logic alarmMeta, alarmSync_n;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         supplyMeta <= 1'b0;
         supplySync <= 1'b0;
         supplyPrev <= 1'b0;
         alarmMeta <= 1'b1;
         alarmSync_n <= 1'b1;
      end else begin
         supplyMeta <= supplyOk;
         supplySync <= supplyMeta;
         supplyPrev <= supplySync;
         alarmMeta <= thermalAlarmIn_n;
         alarmSync_n <= alarmMeta;
      end
   end

   // ******************************************************************
   // Power-good guard
   // ******************************************************************
   // A supply already high at reset also counts, as the synchronisers reset low; only
   // a fresh rising edge lets the block run, so a glitchy start cannot slip in.
   tapg_guard_type guard, next_guard;
   wire supplyRise = supplySync && !supplyPrev;

   always_comb begin
      next_guard = guard;
      unique case (guard)
         TAPG_GATED: if (supplyRise) next_guard = TAPG_RUN; // [R10]
         TAPG_RUN: if (!supplySync) next_guard = TAPG_GATED; // [R10]
         default: next_guard = TAPG_GATED;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) guard <= TAPG_GATED;
      else guard <= next_guard;
   end

   wire running = (guard == TAPG_RUN);

   // ******************************************************************
   // Alarm direction and throttle
   // ******************************************************************
   logic bidir;
   logic driveAlarm;
   logic throttle;
   logic [1:0] driveHist;

   // Our own drive is masked out of the sampled pin so the device never
   // takes its own alarm as an external request. The pin reaches the logic
   // through two flip-flops, so the mask is held for two cycles after the
   // drive ends; the price is that a platform pull in that window is missed.
   wire ownDrive = driveAlarm || (|driveHist);
   wire externalAlarm = bidir && !alarmSync_n && !ownDrive; // [R3]
   wire next_drive = running && sensorAtMaxTemp; // [R1]
   wire next_throttle = running && ctrl.throttleEnable
                        && (next_drive || externalAlarm); // [R2] [R3] [R4]

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bidir <= `TAPG_BIDIR_EN_RST;
         driveAlarm <= 1'b0;
         throttle <= 1'b0;
         driveHist <= 2'h0;
      end else begin
         if (!running) bidir <= `TAPG_BIDIR_EN_RST;
         else if (ctrl.bidirEnableReq) bidir <= 1'b1; // [R5]
         driveAlarm <= next_drive; // [R1]
         throttle <= next_throttle; // [R2] [R4]
         driveHist <= {driveHist[0], driveAlarm}; // [R3]
      end
   end

   // ******************************************************************
   // Power-state indicator
   // ******************************************************************
   logic psiActive;
   wire psiState = running && (powerState inside {TAPG_PS_HIGH_FREQ, TAPG_PS_MID_FREQ,
      TAPG_PS_LOW_FREQ, TAPG_PS_DEEP_SLEEP, TAPG_PS_DEEPER_SLEEP}); // [R6]

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) psiActive <= 1'b0;
      else psiActive <= psiState; // [R6]
   end

   assign thermalAlarm.alarmOut = 1'b0;
   assign thermalAlarm.alarmOe_n = !driveAlarm; // [R1]
   assign thermalThrottleUnit = throttle;
   assign powerStateIndicator_n = !psiActive;
   assign bidirEnabled = bidir;
   assign logicGated = !running;

   // ******************************************************************
   // Checks
   // ******************************************************************
   // These look only at what the block drives; the platform's duties on the
   // power-good input are kept by the platform model on the bench side.
   property p_alarm_drive;
      @(posedge core_clk) disable iff (!resetn)
      (running && sensorAtMaxTemp) |=> !thermalAlarm.alarmOe_n;
   endproperty
   a_alarm_drive: assert property (p_alarm_drive) else $error("alarm not driven"); // [R1]

   property p_throttle_with_alarm;
      @(posedge core_clk) disable iff (!resetn)
      ($past(ctrl.throttleEnable) && !thermalAlarm.alarmOe_n) |-> thermalThrottleUnit;
   endproperty
   a_throttle_with_alarm: assert property (p_throttle_with_alarm) // [R2]
      else $error("alarm without throttle");

   property p_ext_throttle;
      @(posedge core_clk) disable iff (!resetn)
      (running && bidir && ctrl.throttleEnable && !alarmSync_n && !ownDrive)
      |=> thermalThrottleUnit;
   endproperty
   a_ext_throttle: assert property (p_ext_throttle) else $error("no ext throttle"); // [R3]

   property p_ext_hold;
      @(posedge core_clk) disable iff (!resetn)
      (thermalThrottleUnit && !sensorAtMaxTemp && !$past(sensorAtMaxTemp)
       && $fell(alarmSync_n) == 1'b0 && alarmSync_n && !driveAlarm) |=> !thermalThrottleUnit;
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("throttle held after release"); // [R4]

   property p_output_only;
      @(posedge core_clk) disable iff (!resetn)
      (!bidir && !sensorAtMaxTemp) |=> !thermalThrottleUnit;
   endproperty
   a_output_only: assert property (p_output_only) // [R5]
      else $error("input used while output");

   property p_psi;
      @(posedge core_clk) disable iff (!resetn)
      running |=> (powerStateIndicator_n == ($countones($past(powerState)) != 1));
   endproperty
   a_psi: assert property (p_psi) else $error("indicator wrong"); // [R6]

   property p_gated_quiet;
      @(posedge core_clk) disable iff (!resetn)
      (!running ##1 !running) |-> (thermalAlarm.alarmOe_n && !thermalThrottleUnit
                                   && powerStateIndicator_n);
   endproperty
   a_gated_quiet: assert property (p_gated_quiet) else $error("active while gated"); // [R10]

   property p_resume_edge;
      @(posedge core_clk) disable iff (!resetn)
      $rose(running) |-> $past(supplyRise);
   endproperty
   a_resume_edge: assert property (p_resume_edge) else $error("resumed without edge"); // [R10]

   property p_alarm_release;
      @(posedge core_clk) disable iff (!resetn)
      !(running && sensorAtMaxTemp) |=> thermalAlarm.alarmOe_n;
   endproperty
   a_alarm_release: assert property (p_alarm_release) // [R1]
      else $error("alarm driven without sensor");

   property p_throttle_disabled;
      @(posedge core_clk) disable iff (!resetn)
      !ctrl.throttleEnable |=> !thermalThrottleUnit;
   endproperty
   a_throttle_disabled: assert property (p_throttle_disabled) // [R3]
      else $error("throttle while disabled");

   property p_bidir_set;
      @(posedge core_clk) disable iff (!resetn)
      (running && ctrl.bidirEnableReq) |=> bidirEnabled;
   endproperty
   a_bidir_set: assert property (p_bidir_set) // [R5]
      else $error("bidirection not enabled");

   property p_bidir_cleared;
      @(posedge core_clk) disable iff (!resetn)
      !running |=> !bidirEnabled;
   endproperty
   a_bidir_cleared: assert property (p_bidir_cleared) // [R5]
      else $error("bidirection kept while gated");

   property p_supply_drop;
      @(posedge core_clk) disable iff (!resetn)
      (running && !supplySync) |=> !running;
   endproperty
   a_supply_drop: assert property (p_supply_drop) // [R10]
      else $error("still running after supply drop");

endmodule // tapg_sideband

//--- tb/tapg_platform.sv
// Platform model that drives the power-good input and may pull the alarm pin low.
`timescale 1ns/1ps
module tapg_platform (
   input wire logic core_clk,
   input wire logic supplyGood,
   input wire logic pullAlarm,
   output logic supplyOk,
   output logic alarmPull_n
);
   // Power-good moves only on a clock edge, so it stays clean and monotonic.
   initial supplyOk = 1'b0;
   always @(posedge core_clk) begin
      supplyOk <= supplyGood;
   end
   // When released, the pin returns to its pull-up level.
   assign alarmPull_n = ~pullAlarm;
endmodule // tapg_platform

//--- tb/tapg_bench.sv
// Testbench for the thermal alarm and power-good sideband.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module thermal_alarm_power_good_sideband_bench;
   import tapg_pkg::*;
   logic core_clk = 1'b0, resetn = 1'b0, sensorAtMaxTemp = 1'b0;
   logic supplyGood = 1'b0, pullAlarm = 1'b0, supplyOk, alarmPull_n;
   logic thermalThrottleUnit, powerStateIndicator_n, bidirEnabled, logicGated;
   tapg_ctrl_type ctrl = '0;
   tapg_pstate_type powerState = TAPG_PS_HIGH_FREQ;
   tapg_pin_type thermalAlarm;
   int failures = 0, checks_done = 0, cycles = 0;
   logic [4:0] codes [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00, 5'h03};
   wire pinLevel = alarmPull_n & (thermalAlarm.alarmOe_n | thermalAlarm.alarmOut);
   always #50 core_clk = ~core_clk;
   tapg_platform tapg_platform_i (.core_clk(core_clk), .supplyGood(supplyGood),
      .pullAlarm(pullAlarm), .supplyOk(supplyOk), .alarmPull_n(alarmPull_n));
   tapg_sideband tapg_sideband_i (.core_clk(core_clk), .resetn(resetn),
      .sensorAtMaxTemp(sensorAtMaxTemp), .ctrl(ctrl), .powerState(powerState),
      .supplyOk(supplyOk), .thermalAlarmIn_n(pinLevel), .thermalAlarm(thermalAlarm),
      .thermalThrottleUnit(thermalThrottleUnit), .powerStateIndicator_n(powerStateIndicator_n),
      .bidirEnabled(bidirEnabled), .logicGated(logicGated));
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #10;
   endtask
   task automatic power_up();
      `CHK("gated", 1'b1, logicGated)
      `CHK("bidir", 1'b0, bidirEnabled)
      supplyGood = 1'b1;
      cyc(6);
      `CHK("gated", 1'b0, logicGated)
   endtask
   task automatic sensor_alarm();
      for (int en = 0; en < 2; en++) begin
         ctrl.throttleEnable = en[0];
         sensorAtMaxTemp = 1'b1;
         cyc(2);
         `CHK("alarmOe_n", 1'b0, thermalAlarm.alarmOe_n)
         `CHK("throttle", en[0], thermalThrottleUnit)
         `CHK("alarmOut", 1'b0, thermalAlarm.alarmOut)
         sensorAtMaxTemp = 1'b0;
         cyc(2);
         `CHK("alarmOe_n", 1'b1, thermalAlarm.alarmOe_n)
      end
   endtask
   task automatic ext_alarm();
      pullAlarm = 1'b1;
      cyc(5);
      `CHK("throttle", 1'b0, thermalThrottleUnit)
      pullAlarm = 1'b0;
      ctrl.bidirEnableReq = 1'b1;
      cyc(2);
      ctrl.bidirEnableReq = 1'b0;
      `CHK("bidir", 1'b1, bidirEnabled)
      pullAlarm = 1'b1;
      cyc(5);
      `CHK("throttle", 1'b1, thermalThrottleUnit)
      cyc(20);
      `CHK("throttle", 1'b1, thermalThrottleUnit)
      pullAlarm = 1'b0;
      cyc(5);
      `CHK("throttle", 1'b0, thermalThrottleUnit)
      sensorAtMaxTemp = 1'b1;
      cyc(2);
      `CHK("throttle", 1'b1, thermalThrottleUnit)
      sensorAtMaxTemp = 1'b0;
      cyc(2);
      `CHK("throttle", 1'b0, thermalThrottleUnit)
      cyc(1);
      `CHK("throttle", 1'b0, thermalThrottleUnit)
   endtask
   task automatic states();
      for (int i = 0; i < 7; i++) begin
         powerState = tapg_pstate_type'(codes[i]);
         cyc(3);
         `CHK("indicator_n", ($countones(codes[i]) == 1) ? 1'b0 : 1'b1, powerStateIndicator_n)
      end
   endtask
   task automatic supply_drop();
      supplyGood = 1'b0;
      cyc(5);
      `CHK("gated", 1'b1, logicGated)
      `CHK("bidir", 1'b0, bidirEnabled)
      sensorAtMaxTemp = 1'b1;
      cyc(2);
      `CHK("alarmOe_n", 1'b1, thermalAlarm.alarmOe_n)
      sensorAtMaxTemp = 1'b0;
      supplyGood = 1'b1;
      cyc(6);
      `CHK("gated", 1'b0, logicGated)
   endtask
   task automatic summarize();
      $display("Checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      cyc(2);
      resetn = 1'b1;
      cyc(2);
      power_up();
      sensor_alarm();
      ext_alarm();
      states();
      supply_drop();
      summarize();
   end
endmodule // thermal_alarm_power_good_sideband_bench
